// >>> mfcb_pkg.sv
// constants for the motor fault configuration bank
//------------------------------------------------------------------------
// Overview of operation
// R1: speed lock enable bit gates overspeed fault
// R2: back-emf lock enable bit gates back-emf fault
// R3: absent motor enable bit gates no-motor fault
// R4: overspeed threshold 130 to 200 percent, 10 steps
// R5: back-emf threshold 10 to 80 percent, 10 steps
// R6: no-motor current threshold from eight-entry table
// R7: current lock codes 0-3 latch with drive action
// R8: codes 4-7 auto retry, latch past retry limit
// R9: code 8 reports only, no driver action
// R10: codes 9-15 disable current limit lock detection
// R11: current lock deglitch 0 to 15 microseconds
// R12: supply low limit, code 0 means none
// R13: undervoltage either latches or clears in bounds
// R14: supply high limit 20 to 35 volts
// R15: overvoltage either latches or clears in bounds
// R16: retry limit: unlimited, 2,3,5,7,10,15,20
// R17: all fields read write, reset to zero
// R18: field writes act on next evaluation
//------------------------------------------------------------------------
package mfcb_pkg;
	// register map, byte addresses
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK = 8'h08;
	localparam logic [7:0] ADDR_STATE = 8'h0C;
	localparam logic [7:0] ADDR_CTRL = 8'h10;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [6:0] STATUS_RESET = 7'h00;
	localparam logic [6:0] MASK_RESET = 7'h00;
	// configuration word field positions
	localparam int OVS_EN_BIT = 30;
	localparam int BEMF_EN_BIT = 29;
	localparam int NOMTR_EN_BIT = 28;
	localparam int OVS_THR_LSB = 25;
	localparam int BEMF_THR_LSB = 22;
	localparam int NOMTR_THR_LSB = 19;
	localparam int ILIM_RESP_LSB = 15;
	localparam int ILIM_FILT_LSB = 11;
	localparam int LOW_LIM_LSB = 8;
	localparam int LOW_REC_BIT = 7;
	localparam int HIGH_LIM_LSB = 4;
	localparam int HIGH_REC_BIT = 3;
	localparam int RETRY_LSB = 0;
	// status and mask bit positions
	localparam int ST_OVS = 0;
	localparam int ST_BEMF = 1;
	localparam int ST_NOMTR = 2;
	localparam int ST_ILIM = 3;
	localparam int ST_LOW = 4;
	localparam int ST_HIGH = 5;
	localparam int ST_LATCH = 6;
	localparam int CTRL_CLEAR_BIT = 0;
	// current limit response codes
	localparam logic [3:0] ILIM_AUTO_FIRST = 4'h4;
	localparam logic [3:0] ILIM_REPORT = 4'h8;
	// thresholds
	localparam logic [7:0] OVS_PCT_BASE = 8'h82;
	localparam logic [7:0] BEMF_PCT_BASE = 8'h0A;
	localparam logic [7:0] PCT_STEP = 8'h0A;
	localparam logic [7:0] PCT_SCALE = 8'h64;
	localparam logic [7:0][15:0] NOMTR_MA = {16'h03E8, 16'h02EE,
		16'h01F4, 16'h00FA, 16'h007D, 16'h0064, 16'h004B, 16'h0032};
	localparam logic [7:0][15:0] LOW_MV = {16'h30D4, 16'h2710,
		16'h1D4C, 16'h1770, 16'h157C, 16'h1388, 16'h1194, 16'h0000};
	localparam logic [7:0][15:0] HIGH_MV = {16'h88B8, 16'h7EF4,
		16'h7530, 16'h6B6C, 16'h61A8, 16'h57E4, 16'h4E20, 16'h0000};
	localparam logic [7:0][4:0] RETRY_MAX = {5'h14, 5'h0F, 5'h0A,
		5'h07, 5'h05, 5'h03, 5'h02, 5'h00};
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int US_NS = 1000;
	localparam int US_TICK_CYC = US_NS / CLK_PERIOD_NS;
	localparam int LOCK_RETRY_US = 1000;
	localparam int LOCK_RETRY_CYC = LOCK_RETRY_US * US_TICK_CYC;
endpackage : mfcb_pkg

// >>> mfcb_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module mfcb_sync3 (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pin in, clean level out
	input wire logic pin_i,
	output logic level_o
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// change counts once stages two and three agree
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_o <= 1'b0;
		end else begin
			s1_reg <= pin_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				level_o <= s3_reg;
		end
	end
endmodule : mfcb_sync3

// >>> mfcb_bank.sv
// fault configuration word, detectors and wishbone slave
`timescale 1ns/1ns
module mfcb_bank #(
	parameter int RETRY_CYC = mfcb_pkg::LOCK_RETRY_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// measurements from the control loop
	input wire logic motor_run_i,
	input wire logic [15:0] speed_i,
	input wire logic [15:0] max_speed_i,
	input wire logic [15:0] bemf_i,
	input wire logic [15:0] bemf_expect_i,
	input wire logic [15:0] phase_current_ma_i,
	input wire logic [15:0] supply_mv_i,
	// comparator pin, asynchronous
	input wire logic ilimit_hit_i,
	// fault outputs
	output logic overspeed_lock_o,
	output logic backemf_lock_o,
	output logic absent_motor_lock_o,
	output logic supply_low_fault_o,
	output logic supply_high_fault_o,
	output logic driver_override_o,
	output logic [1:0] driver_action_o,
	output logic fault_indicator_pin_n_o,
	output logic irq_o
);
	typedef enum logic [1:0] {
		ILS_IDLE,
		ILS_RETRY,
		ILS_LATCHED
	} mfcb_ilim_state_e;

	//--------------------------------------------------------------------
	// bus decode
	//--------------------------------------------------------------------
	logic [31:0] cfg_reg;
	logic [6:0] status_reg;
	logic [6:0] mask_reg;
	logic [31:0] rdata_next;
	logic [31:0] state_word;
	logic [31:0] sel_mask;
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = req & wb_we_i;
	wire hit_cfg = wb_adr_i == mfcb_pkg::ADDR_CFG;
	wire hit_status = wb_adr_i == mfcb_pkg::ADDR_STATUS;
	wire hit_mask = wb_adr_i == mfcb_pkg::ADDR_MASK;
	wire hit_state = wb_adr_i == mfcb_pkg::ADDR_STATE;
	wire hit_ctrl = wb_adr_i == mfcb_pkg::ADDR_CTRL;
	wire wr_cfg = wr & hit_cfg;
	wire wr_status = wr & hit_status;
	wire wr_mask = wr & hit_mask;
	wire clear_cmd = wr & hit_ctrl & wb_sel_i[0]
		& wb_dat_i[mfcb_pkg::CTRL_CLEAR_BIT];
	assign sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] cfg_next = (cfg_reg & ~sel_mask) | (wb_dat_i & sel_mask);
	wire [6:0] wmask = wb_dat_i[6:0] & {7{wb_sel_i[0]}};
	// unmapped addresses and the clear register read as zero
	assign rdata_next = hit_cfg ? cfg_reg :
		hit_status ? {25'h0, status_reg} :
		hit_mask ? {25'h0, mask_reg} :
		hit_state ? state_word : 32'h0000_0000;

	//--------------------------------------------------------------------
	// configuration fields
	//--------------------------------------------------------------------
	wire ovs_en = cfg_reg[mfcb_pkg::OVS_EN_BIT];
	wire bemf_en = cfg_reg[mfcb_pkg::BEMF_EN_BIT];
	wire nomtr_en = cfg_reg[mfcb_pkg::NOMTR_EN_BIT];
	wire [2:0] ovs_code = cfg_reg[mfcb_pkg::OVS_THR_LSB +: 3];
	wire [2:0] bemf_code = cfg_reg[mfcb_pkg::BEMF_THR_LSB +: 3];
	wire [2:0] nomtr_code = cfg_reg[mfcb_pkg::NOMTR_THR_LSB +: 3];
	wire [3:0] ilim_resp = cfg_reg[mfcb_pkg::ILIM_RESP_LSB +: 4];
	wire [3:0] filt_code = cfg_reg[mfcb_pkg::ILIM_FILT_LSB +: 4];
	wire [2:0] low_code = cfg_reg[mfcb_pkg::LOW_LIM_LSB +: 3];
	wire low_auto = cfg_reg[mfcb_pkg::LOW_REC_BIT];
	wire [2:0] high_code = cfg_reg[mfcb_pkg::HIGH_LIM_LSB +: 3];
	wire high_auto = cfg_reg[mfcb_pkg::HIGH_REC_BIT];
	wire [2:0] retry_code = cfg_reg[mfcb_pkg::RETRY_LSB +: 3];

	//--------------------------------------------------------------------
	// threshold compares, all live on the stored word
	//--------------------------------------------------------------------
	wire [7:0] ovs_pct = mfcb_pkg::OVS_PCT_BASE
		+ 8'(ovs_code) * mfcb_pkg::PCT_STEP; // R4
	wire [7:0] bemf_pct = mfcb_pkg::BEMF_PCT_BASE
		+ 8'(bemf_code) * mfcb_pkg::PCT_STEP; // R5
	// scaled by 100 on both sides to avoid a divider
	wire [23:0] speed_x100 = 24'(speed_i) * 24'(mfcb_pkg::PCT_SCALE);
	wire [23:0] speed_lim = 24'(max_speed_i) * 24'(ovs_pct);
	wire [23:0] bemf_x100 = 24'(bemf_i) * 24'(mfcb_pkg::PCT_SCALE);
	wire [23:0] bemf_lim = 24'(bemf_expect_i) * 24'(bemf_pct);
	wire ovs_cond = ovs_en & motor_run_i & (speed_x100 > speed_lim); // R1
	wire bemf_cond = bemf_en & motor_run_i & (bemf_x100 < bemf_lim); // R2
	wire nomtr_cond = nomtr_en & motor_run_i
		& (phase_current_ma_i < mfcb_pkg::NOMTR_MA[nomtr_code]); // R3 R6
	wire low_cond = (low_code != 3'h0)
		& (supply_mv_i < mfcb_pkg::LOW_MV[low_code]); // R12
	wire high_cond = (high_code != 3'h0)
		& (supply_mv_i > mfcb_pkg::HIGH_MV[high_code]); // R14

	//--------------------------------------------------------------------
	// microsecond tick and current limit deglitch
	//--------------------------------------------------------------------
	logic [7:0] div_reg;
	logic [3:0] filt_reg;
	logic ilim_lvl;
	logic ilim_det_q;
	wire us_tick = div_reg == 8'(mfcb_pkg::US_TICK_CYC - 1);
	wire ilim_on = ilim_resp <= mfcb_pkg::ILIM_REPORT; // R10
	wire ilim_det = ilim_on & ilim_lvl & (filt_reg >= filt_code); // R11
	wire ilim_pulse = ilim_det & ~ilim_det_q;

	mfcb_sync3 i_mfcb_sync3 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(ilimit_hit_i),
		.level_o(ilim_lvl)
	);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_reg <= 8'h00;
			filt_reg <= 4'h0;
			ilim_det_q <= 1'b0;
		end else begin
			div_reg <= us_tick ? 8'h00 : div_reg + 8'h01;
			ilim_det_q <= ilim_det;
			if (!ilim_lvl)
				filt_reg <= 4'h0;
			else if (us_tick && filt_reg < filt_code)
				filt_reg <= filt_reg + 4'h1; // R11
		end
	end

	//--------------------------------------------------------------------
	// current limit lock response
	//--------------------------------------------------------------------
	mfcb_ilim_state_e ils_reg;
	mfcb_ilim_state_e ils_next;
	logic [4:0] retry_cnt_reg;
	logic [31:0] retry_tmr_reg;
	logic [1:0] action_reg;
	wire [4:0] retry_lim = mfcb_pkg::RETRY_MAX[retry_code]; // R16
	wire retry_spent = (retry_code != 3'h0) & (retry_cnt_reg >= retry_lim);
	wire resp_latch = ilim_resp < mfcb_pkg::ILIM_AUTO_FIRST;
	wire resp_auto = ~resp_latch & (ilim_resp < mfcb_pkg::ILIM_REPORT);
	wire tmr_done = retry_tmr_reg == 32'(RETRY_CYC - 1);
	wire take = (ils_reg == ILS_IDLE) & ilim_pulse;

	always_comb begin
		ils_next = ils_reg;
		unique case (ils_reg)
			ILS_IDLE: begin
				if (take && resp_latch)
					ils_next = ILS_LATCHED; // R7
				else if (take && resp_auto)
					ils_next = retry_spent ? ILS_LATCHED : ILS_RETRY; // R8
			end
			ILS_RETRY: begin
				if (tmr_done)
					ils_next = ILS_IDLE; // R8
			end
			ILS_LATCHED: begin
				if (clear_cmd)
					ils_next = ILS_IDLE;
			end
			default: ils_next = ILS_IDLE;
		endcase
	end

	// counter resets only on reset or a software clear, so it spans attempts
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ils_reg <= ILS_IDLE;
			action_reg <= 2'h0;
			retry_cnt_reg <= 5'h00;
			retry_tmr_reg <= 32'h0000_0000;
		end else begin
			ils_reg <= ils_next;
			if (take && (resp_latch || resp_auto))
				action_reg <= ilim_resp[1:0]; // R7 R8
			if (clear_cmd)
				retry_cnt_reg <= 5'h00;
			else if (take && resp_auto && !retry_spent
				&& retry_cnt_reg != 5'h1F)
				retry_cnt_reg <= retry_cnt_reg + 5'h01; // R16
			if (ils_reg == ILS_RETRY && !tmr_done)
				retry_tmr_reg <= retry_tmr_reg + 32'h0000_0001;
			else
				retry_tmr_reg <= 32'h0000_0000;
		end
	end

	// report-only code never reaches the driver
	assign driver_override_o = ils_reg != ILS_IDLE; // R9
	assign driver_action_o = action_reg;

	//--------------------------------------------------------------------
	// fault levels
	//--------------------------------------------------------------------
	logic low_reg;
	logic high_reg;
	logic ovs_reg;
	logic bemf_reg;
	logic nomtr_reg;

	// a standing fault survives the clear, the set has priority over it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_reg <= 1'b0;
			high_reg <= 1'b0;
			ovs_reg <= 1'b0;
			bemf_reg <= 1'b0;
			nomtr_reg <= 1'b0;
		end else begin
			ovs_reg <= ovs_cond;
			bemf_reg <= bemf_cond;
			nomtr_reg <= nomtr_cond;
			if (low_cond)
				low_reg <= 1'b1;
			else if (low_auto || clear_cmd)
				low_reg <= 1'b0; // R13
			if (high_cond)
				high_reg <= 1'b1;
			else if (high_auto || clear_cmd)
				high_reg <= 1'b0; // R15
		end
	end

	assign overspeed_lock_o = ovs_reg;
	assign backemf_lock_o = bemf_reg;
	assign absent_motor_lock_o = nomtr_reg;
	assign supply_low_fault_o = low_reg;
	assign supply_high_fault_o = high_reg;

	logic pin_n_reg;
	wire any_fault = ovs_reg | bemf_reg | nomtr_reg | low_reg | high_reg
		| ilim_det | driver_override_o;
	assign fault_indicator_pin_n_o = pin_n_reg;

	//--------------------------------------------------------------------
	// interrupt status
	//--------------------------------------------------------------------
	logic [6:0] lvl_q;
	wire [6:0] lvl_now = {ils_reg == ILS_LATCHED, high_reg, low_reg,
		ilim_det, nomtr_reg, bemf_reg, ovs_reg};
	wire [6:0] events = lvl_now & ~lvl_q;
	wire [6:0] w1c = wr_status ? wmask : 7'h00;
	// set wins over a clear in the same cycle
	wire [6:0] status_next = events | (status_reg & ~w1c);
	assign irq_o = |(status_reg & mask_reg);
	assign state_word = {11'h000, retry_cnt_reg, 6'h00, 2'(ils_reg),
		1'b0, lvl_now};

	//--------------------------------------------------------------------
	// registers and bus answer
	//--------------------------------------------------------------------
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_reg <= mfcb_pkg::CFG_RESET; // R17
			status_reg <= mfcb_pkg::STATUS_RESET;
			mask_reg <= mfcb_pkg::MASK_RESET;
			lvl_q <= 7'h00;
			pin_n_reg <= 1'b1;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			if (wr_cfg)
				cfg_reg <= cfg_next; // R17 R18
			if (wr_mask && wb_sel_i[0])
				mask_reg <= wb_dat_i[6:0];
			status_reg <= status_next;
			lvl_q <= lvl_now;
			pin_n_reg <= ~any_fault;
			wb_ack_o <= req;
			if (req && !wb_we_i)
				wb_dat_o <= rdata_next;
		end
	end

	//--------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------
	AST_OVS_GATED: assert property (@(posedge clk_i) disable iff (rst_i)
		!ovs_en |=> !overspeed_lock_o) // R1
		else $error("overspeed lock while disabled");
	AST_BEMF_GATED: assert property (@(posedge clk_i) disable iff (rst_i)
		!bemf_en |=> !backemf_lock_o) // R2
		else $error("back-emf lock while disabled");
	AST_NOMTR_GATED: assert property (@(posedge clk_i) disable iff (rst_i)
		!nomtr_en |=> !absent_motor_lock_o) // R3
		else $error("absent motor lock while disabled");
	AST_OVS_THR: assert property (@(posedge clk_i) disable iff (rst_i)
		ovs_en && motor_run_i && ovs_code == 3'h7
		&& 24'(speed_i) * 24'h64 > 24'(max_speed_i) * 24'hC8
		|=> overspeed_lock_o) // R4
		else $error("overspeed above 200 percent missed");
	AST_ILIM_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
		take && ilim_resp < 4'h4 |=> ils_reg == ILS_LATCHED
		&& driver_action_o == $past(ilim_resp[1:0])) // R7
		else $error("current lock did not latch");
	AST_RETRY_BACK: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(ils_reg == ILS_RETRY) |-> driver_override_o [*2]) // R8
		else $error("retry dropped drive action early");
	AST_RETRY_LIMIT: assert property (@(posedge clk_i) disable iff (rst_i)
		take && resp_auto && retry_code == 3'h1 && retry_cnt_reg == 5'h02
		|=> ils_reg == ILS_LATCHED) // R8
		else $error("retry limit exceeded without latch");
	AST_REPORT_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
		take && ilim_resp == 4'h8 |=> !driver_override_o
		&& status_reg[mfcb_pkg::ST_ILIM]) // R9
		else $error("report-only code acted on driver");
	AST_ILIM_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		ilim_resp > 4'h8 |-> !ilim_det) // R10
		else $error("disabled current lock detected");
	AST_FILTER: assert property (@(posedge clk_i) disable iff (rst_i)
		ilim_det && filt_code != 4'h0 |-> $past(ilim_lvl)) // R11
		else $error("current lock accepted before deglitch");
	AST_LOW_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
		low_reg && !low_auto && !clear_cmd |=> low_reg) // R13
		else $error("latched undervoltage cleared itself");
	AST_HIGH_AUTO: assert property (@(posedge clk_i) disable iff (rst_i)
		high_reg && high_auto && !high_cond |=> !high_reg) // R15
		else $error("overvoltage did not self clear");
	AST_CFG_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(rst_i) |-> cfg_reg == 32'h0000_0000) // R17
		else $error("configuration not zero after reset");
	AST_CFG_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_cfg && wb_sel_i == 4'hF |=> cfg_reg == $past(wb_dat_i)) // R18
		else $error("configuration write not applied");
endmodule : mfcb_bank

// >>> mfcb_bank_tb.sv
// self-checking bench for the motor fault configuration bank
`timescale 1ns/1ns
module mfcb_bank_tb;
	// short retry time keeps the auto-retry scenario brief
	localparam int RETRY = 20;
	localparam logic [15:0] SP0 = 16'h0000;
	localparam logic [15:0] BM0 = 16'h0064;
	localparam logic [15:0] CU0 = 16'h07D0;
	localparam logic [15:0] SU0 = 16'h3A98;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic motor_run_i = 1'b1;
	logic [15:0] speed_i = SP0;
	logic [15:0] max_speed_i = 16'h0064;
	logic [15:0] bemf_i = BM0;
	logic [15:0] bemf_expect_i = 16'h0064;
	logic [15:0] phase_current_ma_i = CU0;
	logic [15:0] supply_mv_i = SU0;
	logic ilimit_hit_i = 1'b0;
	logic overspeed_lock_o;
	logic backemf_lock_o;
	logic absent_motor_lock_o;
	logic supply_low_fault_o;
	logic supply_high_fault_o;
	logic driver_override_o;
	logic [1:0] driver_action_o;
	logic fault_indicator_pin_n_o;
	logic irq_o;
	logic [31:0] rd;
	int miscompares = 0;
	int num_checks = 0;
	logic [15:0] cur_t [8] = '{16'h0032, 16'h004B, 16'h0064, 16'h007D,
		16'h00FA, 16'h01F4, 16'h02EE, 16'h03E8};
	logic [15:0] low_t [8] = '{16'h0000, 16'h1194, 16'h1388, 16'h157C,
		16'h1770, 16'h1D4C, 16'h2710, 16'h30D4};

	mfcb_bank #(.RETRY_CYC(RETRY)) i_mfcb_bank (
		.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.motor_run_i(motor_run_i), .speed_i(speed_i),
		.max_speed_i(max_speed_i), .bemf_i(bemf_i),
		.bemf_expect_i(bemf_expect_i),
		.phase_current_ma_i(phase_current_ma_i),
		.supply_mv_i(supply_mv_i), .ilimit_hit_i(ilimit_hit_i),
		.overspeed_lock_o(overspeed_lock_o),
		.backemf_lock_o(backemf_lock_o),
		.absent_motor_lock_o(absent_motor_lock_o),
		.supply_low_fault_o(supply_low_fault_o),
		.supply_high_fault_o(supply_high_fault_o),
		.driver_override_o(driver_override_o),
		.driver_action_o(driver_action_o),
		.fault_indicator_pin_n_o(fault_indicator_pin_n_o),
		.irq_o(irq_o)
	);

	always #4 clk_i = ~clk_i;

	//------------------------------------------------------------------
	// tasks
	//------------------------------------------------------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check

	// entered just after a rising edge; leaves one idle cycle behind
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 40) begin
			n++;
			@(posedge clk_i);
		end
		if (n == 40) begin
			miscompares++;
			$display("unexpected at %0t: no bus answer", $time);
			print_verdict();
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : bus

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 4'hF, 32'h0000_0000);
		check(rd, exp);
	endtask : rchk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, 4'hF, d);
	endtask : wr

	task automatic state_chk(input logic [1:0] exp);
		bus(8'h0C, 1'b0, 4'hF, 32'h0000_0000);
		check({30'h0, rd[9:8]}, {30'h0, exp});
	endtask : state_chk

	// result order: high, low, absent motor, back-emf, overspeed
	task automatic probe(input logic [31:0] cfg, input logic [15:0] sp,
		input logic [15:0] bm, input logic [15:0] cu,
		input logic [15:0] su, input logic [4:0] exp);
		speed_i <= sp;
		bemf_i <= bm;
		phase_current_ma_i <= cu;
		supply_mv_i <= su;
		wr(8'h00, cfg);
		repeat (3) @(posedge clk_i);
		check({27'h0, supply_high_fault_o, supply_low_fault_o,
			absent_motor_lock_o, backemf_lock_o, overspeed_lock_o},
			{27'h0, exp});
	endtask : probe

	// pin held high for n cycles, then a few cycles to settle
	task automatic pulse(input int n);
		ilimit_hit_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		ilimit_hit_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : pulse

	//------------------------------------------------------------------
	// main sequence
	//------------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		check({31'h0, fault_indicator_pin_n_o}, 32'h1);
		rchk(8'h00, 32'h0000_0000);
		rchk(8'h04, 32'h0000_0000);
		rchk(8'h08, 32'h0000_0000);
		wr(8'h00, 32'hFFFF_FFFF);
		rchk(8'h00, 32'hFFFF_FFFF);
		bus(8'h00, 1'b1, 4'h1, 32'h0000_0000);
		rchk(8'h00, 32'hFFFF_FF00);
		wr(8'h40, 32'hFFFF_FFFF);
		rchk(8'h40, 32'h0000_0000);
		probe(32'h0, 16'h03E8, 16'h0000, 16'h0000, SU0, 5'h00);
		for (int c = 0; c < 8; c++) begin
			probe(32'h4000_0000 | (c << 25), 16'h83 + 16'h0A * c,
				BM0, CU0, SU0, 5'h01);
			probe(32'h4000_0000 | (c << 25), 16'h82 + 16'h0A * c,
				BM0, CU0, SU0, 5'h00);
			probe(32'h2000_0000 | (c << 22), SP0, 16'h09 + 16'h0A * c,
				CU0, SU0, 5'h02);
			probe(32'h2000_0000 | (c << 22), SP0, 16'h0A + 16'h0A * c,
				CU0, SU0, 5'h00);
			probe(32'h1000_0000 | (c << 19), SP0, BM0, cur_t[c] - 16'h1,
				SU0, 5'h04);
			probe(32'h1000_0000 | (c << 19), SP0, BM0, cur_t[c], SU0,
				5'h00);
		end
		probe(32'h80, SP0, BM0, CU0, 16'h0001, 5'h00);
		for (int c = 1; c < 8; c++) begin
			probe((c << 8) | 32'h80, SP0, BM0, CU0, low_t[c] - 16'h1,
				5'h08);
			probe((c << 8) | 32'h80, SP0, BM0, CU0, low_t[c], 5'h00);
			probe((c << 4) | 32'h8, SP0, BM0, CU0,
				16'h4E21 + 16'h09C4 * (c - 1), 5'h10);
			probe((c << 4) | 32'h8, SP0, BM0, CU0,
				16'h4E20 + 16'h09C4 * (c - 1), 5'h00);
		end
		// latch modes hold the fault after the supply recovers
		probe(32'h100, SP0, BM0, CU0, 16'h0FA0, 5'h08);
		probe(32'h100, SP0, BM0, CU0, SU0, 5'h08);
		check({31'h0, fault_indicator_pin_n_o}, 32'h0);
		wr(8'h10, 32'h1);
		probe(32'h100, SP0, BM0, CU0, SU0, 5'h00);
		probe(32'h10, SP0, BM0, CU0, 16'h55F0, 5'h10);
		probe(32'h10, SP0, BM0, CU0, SU0, 5'h10);
		wr(8'h10, 32'h1);
		probe(32'h10, SP0, BM0, CU0, SU0, 5'h00);
		check({31'h0, fault_indicator_pin_n_o}, 32'h1);

		//--------------------------------------------------------------
		// interrupt: sticky status, mask, write-one-to-clear
		//--------------------------------------------------------------
		wr(8'h04, 32'h7F);
		wr(8'h08, 32'h10);
		check({31'h0, irq_o}, 32'h0);
		probe(32'h180, SP0, BM0, CU0, 16'h0FA0, 5'h08);
		probe(32'h180, SP0, BM0, CU0, SU0, 5'h00);
		check({31'h0, irq_o}, 32'h1);
		rchk(8'h04, 32'h10);
		wr(8'h08, 32'h0);
		check({31'h0, irq_o}, 32'h0);
		wr(8'h08, 32'h10);
		check({31'h0, irq_o}, 32'h1);
		wr(8'h04, 32'h10);
		check({31'h0, irq_o}, 32'h0);
		rchk(8'h04, 32'h0);

		//--------------------------------------------------------------
		// current-limit lock responses
		//--------------------------------------------------------------
		for (int c = 0; c < 4; c++) begin
			wr(8'h00, c << 15);
			pulse(10);
			check({31'h0, driver_override_o}, 32'h1);
			check({30'h0, driver_action_o}, c);
			state_chk(2'h2);
			wr(8'h10, 32'h1);
			check({31'h0, driver_override_o}, 32'h0);
		end
		wr(8'h04, 32'h7F);
		wr(8'h00, 32'h0004_0000);
		pulse(10);
		check({31'h0, driver_override_o}, 32'h0);
		rchk(8'h04, 32'h08);
		wr(8'h04, 32'h7F);
		for (int c = 9; c < 16; c += 6) begin
			wr(8'h00, c << 15);
			pulse(10);
			check({31'h0, driver_override_o}, 32'h0);
			rchk(8'h04, 32'h00);
		end
		// two microsecond filter: short glitch ignored, long one taken
		wr(8'h00, 32'h0000_1000);
		pulse(100);
		check({31'h0, driver_override_o}, 32'h0);
		pulse(400);
		check({31'h0, driver_override_o}, 32'h1);
		wr(8'h10, 32'h1);
		// recirculation with two retries allowed, third detection latches
		wr(8'h00, 32'h0002_8001);
		for (int k = 0; k < 2; k++) begin
			pulse(10);
			check({31'h0, driver_override_o}, 32'h1);
			check({30'h0, driver_action_o}, 32'h1);
			state_chk(2'h1);
			repeat (RETRY + 10) @(posedge clk_i);
			check({31'h0, driver_override_o}, 32'h0);
			state_chk(2'h0);
		end
		pulse(10);
		state_chk(2'h2);
		check({31'h0, driver_override_o}, 32'h1);
		wr(8'h10, 32'h1);
		state_chk(2'h0);
		// unlimited retries: a third detection still retries
		wr(8'h00, 32'h0002_0000);
		for (int k = 0; k < 3; k++) begin
			pulse(10);
			check({30'h0, driver_action_o}, 32'h0);
			state_chk(2'h1);
			repeat (RETRY + 10) @(posedge clk_i);
		end
		print_verdict();
	end

	initial begin
		repeat (40000) @(posedge clk_i);
		miscompares++;
		$display("unexpected at %0t: run did not finish", $time);
		print_verdict();
	end
endmodule : mfcb_bank_tb
